// File: logic/fwl_pkg.sv
// Shared constants and carrier types of the segment access firewall.
// Assumes one system clock; all users import the whole package.
package fwl_pkg;

  // Segment indices
  localparam int FW_NSEG = 3;
  localparam int FW_SEG_CODE = 0;
  localparam int FW_SEG_NVD = 1;
  localparam int FW_SEG_VOL = 2;

  // Granularity and largest size of each segment
  localparam int FW_GRAN_BYTES [FW_NSEG] = '{256, 256, 64};
  localparam int FW_MAX_KB [FW_NSEG] = '{1024, 1024, 256};
  localparam int FW_KB = 1024;

  // Field widths: start in granules, length in granules
  localparam int FW_SW = 12;
  localparam int FW_LW = 13;

  // Entry point of the call gate, from the code segment start
  localparam logic [31:0] FW_GATE_OFS = 32'h0000_0004;

  // Register byte offsets
  localparam logic [7:0] FW_OFS_SEG = 8'h00;
  localparam logic [7:0] FW_OFS_STEP = 8'h08;
  localparam logic [7:0] FW_OFS_LEN = 8'h04;
  localparam logic [7:0] FW_OFS_CTRL = 8'h18;
  localparam logic [7:0] FW_OFS_STAT = 8'h1C;
  localparam logic [7:0] FW_OFS_VADDR = 8'h20;

  // Control and status bit positions
  localparam int FW_CTL_EN = 0;
  localparam int FW_CTL_SHARE = 1;
  localparam int FW_CTL_EXEC = 2;
  localparam int FW_CTL_CSRAM = 3;
  localparam int FW_ST_OPEN = 0;
  localparam int FW_ST_VIOL = 1;
  localparam int FW_ST_EN = 2;

  // Reset values
  localparam logic [FW_SW-1:0] FW_START_RST = 12'h000;
  localparam logic [FW_LW-1:0] FW_LEN_RST = 13'h0000;
  localparam logic [31:0] FW_ADDR_RST = 32'h0000_0000;

  // Core access as seen by the firewall
  typedef struct packed {
    logic valid;
    logic fetch;
    logic [31:0] addr;
  } fwl_acc_t;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } fwl_bus_t;

endpackage : fwl_pkg

// File: logic/fwl_seg_match.sv
// Address match of one protected segment, purely combinational.
// Assumes start and length are given in granules of 2**GRAN_SH bytes.
`timescale 1ns/1ps
module fwl_seg_match
  import fwl_pkg::*;
#(
  parameter int GRAN_SH = 8
)
(
  input wire logic [31:0] addr,
  input wire logic [31:0] base,
  input wire logic [FW_SW-1:0] start,
  input wire logic [FW_LW-1:0] len,
  output logic hit,
  output logic gate
);

  logic [31:0] off;
  logic [31:0] lo;
  logic [31:0] hi;

  // Shift beyond a word would wrap the window
  if (GRAN_SH < 1 || GRAN_SH + FW_LW > 31)
  begin : g_bad
    $error("fwl_seg_match: granule shift out of range");
  end

  // Window in bytes relative to the memory area base
  assign off = addr - base;
  assign lo = 32'(start) << GRAN_SH;
  assign hi = lo + (32'(len) << GRAN_SH);
  assign hit = (addr >= base) && (off >= lo) && (off < hi);
  // Only the single entry word counts as the gate
  assign gate = hit && (off == lo + FW_GATE_OFS);

endmodule : fwl_seg_match

// File: logic/fwl_firewall.sv
// Segment access firewall: watches core accesses against three segments.
// Assumes core access and register port come from logic on CLK.
//
// Summary of operation
// - There are exactly three segments, code, flash data and SRAM data.
// - Software sets the start and the length of each segment.
// - Code sits in flash, or in the primary SRAM bank when executable.
// - Code length reaches 1024 Kbyte, start and length in 256-byte steps.
// - Flash data sits in flash, up to 1024 Kbyte, in 256-byte steps.
// - SRAM data sits in the primary SRAM bank, up to 256 Kbyte, in 64-byte steps.
// - Protection opens only through a fetch of the call gate entry.
// - A setting lets unprotected code share the SRAM data segment.
// - A setting allows or forbids fetches from the SRAM data segment.
`timescale 1ns/1ps
module fwl_firewall
  import fwl_pkg::*;
#(
  parameter logic [31:0] FLASH_BASE = 32'h0000_0000,
  parameter logic [31:0] SRAM_BASE = 32'h2000_0000
)
(
  input wire logic CLK,
  input wire logic RESET,
  input wire fwl_acc_t ACC,
  input wire fwl_bus_t BUS,
  output logic [31:0] RDATA,
  output logic ACC_OK,
  output logic ACC_DENY,
  output logic FW_OPEN
);

  // Segment configuration
  logic [FW_SW-1:0] seg_start [FW_NSEG];
  logic [FW_LW-1:0] seg_len [FW_NSEG];
  logic [31:0] seg_base [FW_NSEG];
  logic [FW_NSEG-1:0] hit;
  logic [FW_NSEG-1:0] gate;

  // Control and status
  logic enabled;
  logic vol_share;
  logic vol_exec;
  logic code_sram;
  logic viol;
  logic [31:0] viol_addr;
  logic cfg_wr_ok;
  logic next_ok;
  logic next_deny;
  logic next_open;
  logic [31:0] next_rdata;

  // Code moves to SRAM only when SRAM data is executable
  assign seg_base[FW_SEG_CODE] = (code_sram && vol_exec) ?
    SRAM_BASE : FLASH_BASE;
  assign seg_base[FW_SEG_NVD] = FLASH_BASE;
  assign seg_base[FW_SEG_VOL] = SRAM_BASE;

  // Coinciding memory areas would make the code base choice meaningless
  if (FLASH_BASE == SRAM_BASE)
  begin : g_bad_base
    $error("fwl_firewall: flash and SRAM bases coincide");
  end

  // One matcher per segment
  for (genvar i = 0; i < FW_NSEG; i++)
  begin : g_seg
    localparam int SH = $clog2(FW_GRAN_BYTES[i]);
    localparam int LMAX = FW_MAX_KB[i] * FW_KB / FW_GRAN_BYTES[i];

    // Largest length must fit the length field
    if (LMAX >= (1 << FW_LW))
    begin : g_bad
      $error("fwl_firewall: length field too narrow");
    end

    fwl_seg_match #(
      .GRAN_SH(SH)
    ) u_match (
      .addr(ACC.addr),
      .base(seg_base[i]),
      .start(seg_start[i]),
      .len(seg_len[i]),
      .hit(hit[i]),
      .gate(gate[i])
    );

    // Start and length writes, length saturates at the segment size
    always_ff @(posedge CLK)
    begin
      if (RESET)
      begin
        seg_start[i] <= FW_START_RST;
        seg_len[i] <= FW_LEN_RST;
      end
      else if (BUS.wr && cfg_wr_ok)
      begin
        if (BUS.addr == FW_OFS_SEG + FW_OFS_STEP * 8'(i))
          seg_start[i] <= BUS.wdata[FW_SW-1:0];
        if (BUS.addr == FW_OFS_SEG + FW_OFS_STEP * 8'(i) + FW_OFS_LEN)
        begin
          if (BUS.wdata > 32'(LMAX))
            seg_len[i] <= FW_LW'(LMAX);
          else
            seg_len[i] <= BUS.wdata[FW_LW-1:0];
        end
      end
    end
  end

  // Settings lock once armed, unless protected code itself changes them
  assign cfg_wr_ok = !enabled || FW_OPEN;

  // Control register; the enable cannot be withdrawn before reset
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      enabled <= 1'b0;
      vol_share <= 1'b0;
      vol_exec <= 1'b0;
      code_sram <= 1'b0;
    end
    else if (BUS.wr && BUS.addr == FW_OFS_CTRL && cfg_wr_ok)
    begin
      enabled <= enabled | BUS.wdata[FW_CTL_EN];
      vol_share <= BUS.wdata[FW_CTL_SHARE];
      vol_exec <= BUS.wdata[FW_CTL_EXEC];
      code_sram <= BUS.wdata[FW_CTL_CSRAM];
    end
  end

  // Access decision for the current core access
  always_comb
  begin
    next_ok = 1'b0;
    next_deny = 1'b0;
    next_open = FW_OPEN;
    if (ACC.valid)
    begin
      if (!enabled)
        next_ok = 1'b1;
      else if (FW_OPEN)
      begin
        if (ACC.fetch && hit[FW_SEG_VOL] && !vol_exec)
          next_deny = 1'b1;
        else
        begin
          next_ok = 1'b1;
          // Fetching outside protected code leaves the protected context
          if (ACC.fetch && !hit[FW_SEG_CODE] &&
              !(hit[FW_SEG_VOL] && vol_exec))
            next_open = 1'b0;
        end
      end
      else if (ACC.fetch && gate[FW_SEG_CODE])
      begin
        next_ok = 1'b1;
        next_open = 1'b1;
      end
      else if (!ACC.fetch && hit[FW_SEG_VOL] && vol_share)
        next_ok = 1'b1;
      else if (|hit)
        next_deny = 1'b1;
      else
        next_ok = 1'b1;
    end
  end

  // Registered access answer and protection state
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      ACC_OK <= 1'b0;
      ACC_DENY <= 1'b0;
      FW_OPEN <= 1'b0;
    end
    else
    begin
      ACC_OK <= next_ok;
      ACC_DENY <= next_deny;
      FW_OPEN <= next_open;
    end
  end

  // Sticky violation flag; a new violation beats a clear in one cycle
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      viol <= 1'b0;
      viol_addr <= FW_ADDR_RST;
    end
    else if (next_deny)
    begin
      viol <= 1'b1;
      viol_addr <= ACC.addr;
    end
    else if (BUS.wr && BUS.addr == FW_OFS_STAT && BUS.wdata[FW_ST_VIOL])
      viol <= 1'b0;
  end

  // Read multiplexer, unmapped offsets read zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    for (int k = 0; k < FW_NSEG; k++)
    begin
      if (BUS.addr == FW_OFS_SEG + FW_OFS_STEP * 8'(k))
        next_rdata = 32'(seg_start[k]);
      if (BUS.addr == FW_OFS_SEG + FW_OFS_STEP * 8'(k) + FW_OFS_LEN)
        next_rdata = 32'(seg_len[k]);
    end
    if (BUS.addr == FW_OFS_CTRL)
    begin
      next_rdata[FW_CTL_EN] = enabled;
      next_rdata[FW_CTL_SHARE] = vol_share;
      next_rdata[FW_CTL_EXEC] = vol_exec;
      next_rdata[FW_CTL_CSRAM] = code_sram;
    end
    if (BUS.addr == FW_OFS_STAT)
    begin
      next_rdata[FW_ST_OPEN] = FW_OPEN;
      next_rdata[FW_ST_VIOL] = viol;
      next_rdata[FW_ST_EN] = enabled;
    end
    if (BUS.addr == FW_OFS_VADDR)
      next_rdata = viol_addr;
  end

  // Read data stand for one cycle only
  always_ff @(posedge CLK)
  begin
    if (RESET)
      RDATA <= 32'h0000_0000;
    else if (BUS.rd)
      RDATA <= next_rdata;
    else
      RDATA <= 32'h0000_0000;
  end

  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  sequence s_closed_armed;
    enabled && !FW_OPEN;
  endsequence

  sequence s_gate_fetch;
    ACC.valid && ACC.fetch && gate[FW_SEG_CODE];
  endsequence

  sequence s_opened;
    ACC_OK && FW_OPEN;
  endsequence

  AST_GATE_OPENS: assert property (
    s_closed_armed ##0 s_gate_fetch |=> s_opened)
    else $error("gate fetch did not open protection");

  AST_OPEN_NEEDS_GATE: assert property (
    $rose(FW_OPEN) |-> $past(ACC.valid) && $past(ACC.fetch) &&
    $past(gate[FW_SEG_CODE]))
    else $error("protection opened without gate fetch");

  AST_CLOSED_BLOCKS: assert property (
    s_closed_armed ##0 (ACC.valid && !ACC.fetch && hit[FW_SEG_NVD])
    |=> ACC_DENY && !ACC_OK && viol)
    else $error("closed data access to flash data not blocked");

  AST_SHARE: assert property (
    s_closed_armed ##0 (ACC.valid && !ACC.fetch && vol_share &&
    hit[FW_SEG_VOL]) |=> ACC_OK && !ACC_DENY)
    else $error("shared SRAM data access refused");

  AST_NOEXEC: assert property (
    (enabled && ACC.valid && ACC.fetch && hit[FW_SEG_VOL] && !vol_exec)
    |=> ACC_DENY)
    else $error("fetch from SRAM data not refused");

  AST_ONE_ANSWER: assert property (
    ACC.valid |=> (ACC_OK ^ ACC_DENY))
    else $error("access answer missing or doubled");

  AST_DISABLED_PASS: assert property (
    !enabled |=> !ACC_DENY)
    else $error("access denied while firewall idle");

  AST_LEN_MAX: assert property (
    seg_len[FW_SEG_VOL] <= 13'h1000 && seg_len[FW_SEG_CODE] <= 13'h1000 &&
    seg_len[FW_SEG_NVD] <= 13'h1000)
    else $error("segment length above its maximum");

  AST_LOCKED: assert property (
    (s_closed_armed ##0 BUS.wr) |=> $stable(seg_start[FW_SEG_CODE]))
    else $error("locked segment start changed");

  AST_VIOL_HOLD: assert property (
    viol && !(BUS.wr && BUS.addr == FW_OFS_STAT) |=> viol)
    else $error("violation flag dropped without clear");

  // A refusal must be recorded even when a clear arrives with it
  AST_VIOL_SET: assert property (
    next_deny |=> viol)
    else $error("refused access not recorded");

  AST_RDATA_IDLE: assert property (
    !BUS.rd |=> (RDATA == 32'h0000_0000))
    else $error("read data shown without a read");

endmodule : fwl_firewall

// File: tb/fwl_core_model.sv
// Core model: issues one instruction or data access per call.
// Assumes the bench calls issue from one process, clocked by CLK.
`timescale 1ns/1ps
module fwl_core_model
  import fwl_pkg::*;
(
  input wire logic CLK,
  output fwl_acc_t ACC
);
  initial ACC = '0;

  // One-cycle access; answer sampled once the taking edge has landed
  task automatic issue(input logic f, input logic [31:0] a);
    @(posedge CLK);
    ACC <= '{1'b1, f, a};
    @(posedge CLK);
    ACC <= '0;
    #1;
  endtask : issue
endmodule : fwl_core_model

// File: tb/test_fwl_firewall.sv
// Bench of the segment firewall: register port and core accesses.
// Assumes default bases: flash at 0, primary_sram_bank at 2000_0000.
`timescale 1ns/1ps
module test_fwl_firewall;
  import fwl_pkg::*;
  logic CLK, RESET;
  fwl_acc_t acc;
  fwl_bus_t bus;
  logic [31:0] RDATA;
  logic ACC_OK, ACC_DENY, FW_OPEN;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  fwl_firewall fwl_firewall_inst (.CLK(CLK), .RESET(RESET), .ACC(acc),
    .BUS(bus), .RDATA(RDATA), .ACC_OK(ACC_OK), .ACC_DENY(ACC_DENY),
    .FW_OPEN(FW_OPEN));
  fwl_core_model fwl_core_model_inst (.CLK(CLK), .ACC(acc));

  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // Watchdog: the whole run needs well under 1000 cycles
  always @(posedge CLK)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge CLK);
    bus <= '0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge CLK);
    bus <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge CLK);
    bus <= '0;
    #1;
    check(RDATA, exp);
  endtask : rd

  // Exactly one of ok and deny, plus the open level
  task automatic ac(input logic f, input logic [31:0] a, input logic ok,
    input logic op);
    fwl_core_model_inst.issue(f, a);
    check({31'h0, ACC_OK}, {31'h0, ok});
    check({31'h0, ACC_DENY}, {31'h0, ~ok});
    check({31'h0, FW_OPEN}, {31'h0, op});
  endtask : ac

  task automatic t_reset();
    rd(8'h1C, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h00, 32'h0);
    rd(8'h24, 32'h0);
    ac(1'b0, 32'h0000_1000, 1'b1, 1'b0);
    $display("test reset done");
  endtask : t_reset

  // Code 1 KB at 1000, data 256 B at 10000, SRAM 128 B at +200
  task automatic t_config();
    wr(8'h00, 32'h10);
    wr(8'h04, 32'h4);
    wr(8'h08, 32'h100);
    wr(8'h0C, 32'h1);
    wr(8'h10, 32'h8);
    wr(8'h14, 32'h2);
    wr(8'h18, 32'h3);
    rd(8'h00, 32'h10);
    rd(8'h14, 32'h2);
    wr(8'h00, 32'h20);
    rd(8'h00, 32'h10);
    rd(8'h1C, 32'h4);
    @(posedge CLK);
    #1;
    check(RDATA, 32'h0);
    $display("test config done");
  endtask : t_config

  // Boundaries of each segment while closed
  task automatic t_closed();
    ac(1'b0, 32'h0000_0FFF, 1'b1, 1'b0);
    ac(1'b0, 32'h0000_1000, 1'b0, 1'b0);
    rd(8'h20, 32'h0000_1000);
    rd(8'h1C, 32'h6);
    ac(1'b0, 32'h0000_13FF, 1'b0, 1'b0);
    ac(1'b0, 32'h0000_1400, 1'b1, 1'b0);
    ac(1'b0, 32'h0001_00FF, 1'b0, 1'b0);
    ac(1'b0, 32'h0001_0100, 1'b1, 1'b0);
    ac(1'b1, 32'h2000_01FF, 1'b1, 1'b0);
    ac(1'b1, 32'h2000_0200, 1'b0, 1'b0);
    ac(1'b0, 32'h2000_0200, 1'b1, 1'b0);
    wr(8'h1C, 32'h2);
    rd(8'h1C, 32'h4);
    $display("test closed done");
  endtask : t_closed

  // Only a fetch of the entry word opens; leaving code closes
  task automatic t_gate();
    ac(1'b1, 32'h0000_1000, 1'b0, 1'b0);
    ac(1'b0, 32'h0000_1004, 1'b0, 1'b0);
    ac(1'b1, 32'h0000_1004, 1'b1, 1'b1);
    ac(1'b0, 32'h0001_0000, 1'b1, 1'b1);
    ac(1'b1, 32'h2000_0200, 1'b0, 1'b1);
    wr(8'h18, 32'h7);
    ac(1'b1, 32'h2000_0200, 1'b1, 1'b1);
    wr(8'h18, 32'hF);
    ac(1'b1, 32'h0000_8000, 1'b1, 1'b0);
    ac(1'b1, 32'h2000_1004, 1'b1, 1'b1);
    $display("test gate done");
  endtask : t_gate

  // Length saturation while open, then sharing off and the lock
  task automatic t_limits();
    wr(8'h14, 32'h0001_0000);
    rd(8'h14, 32'h0000_1000);
    wr(8'h0C, 32'h0000_1001);
    rd(8'h0C, 32'h0000_1000);
    wr(8'h04, 32'hFFFF_FFFF);
    rd(8'h04, 32'h0000_1000);
    wr(8'h04, 32'h4);
    wr(8'h0C, 32'h1);
    wr(8'h14, 32'h2);
    wr(8'h18, 32'h5);
    ac(1'b1, 32'h0000_8000, 1'b1, 1'b0);
    ac(1'b0, 32'h2000_0200, 1'b0, 1'b0);
    wr(8'h18, 32'h0);
    rd(8'h18, 32'h5);
    $display("test limits done");
  endtask : t_limits

  initial
  begin
    RESET = 1'b1;
    bus = '0;
    repeat (16) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    t_reset();
    t_config();
    t_closed();
    t_gate();
    t_limits();
    close_out();
  end
endmodule : test_fwl_firewall
